// File: logic/irfs_level_track.sv
// Purpose: occupancy tracker for one fifo
// Assumes: push and pop are one-cycle pulses on clk_i
// Notes: pushes when full and pops when empty are ignored
`timescale 1ns/1ps
`default_nettype none
module irfs_level_track #(
	parameter int DEPTH = 16,
	parameter int LW = $clog2(DEPTH + 1)
) (
	input wire logic clk_i,           // core clock
	input wire logic rstn_i,          // async reset, low
	input wire logic clr_i,           // synchronous flush
	input wire logic push_i,          // entry written
	input wire logic pop_i,           // entry removed
	input wire logic [LW-1:0] thresh_i, // threshold level
	output logic [LW-1:0] level_o,    // entries held
	output logic full_o,              // no free entry
	output logic empty_o,             // nothing held
	output logic above_o              // level over threshold
);
	logic push_ok;
	logic pop_ok;

	// flags follow the live count, never latched
	assign full_o = (level_o == LW'(DEPTH));
	assign empty_o = (level_o == '0);
	assign above_o = (level_o > thresh_i);
	assign push_ok = push_i && !full_o;
	assign pop_ok = pop_i && !empty_o;

	// count update, flush wins over traffic
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			level_o <= '0;
		end else if (clr_i) begin
			level_o <= '0;
		end else if (push_ok && !pop_ok) begin
			level_o <= level_o + LW'(1);
		end else if (pop_ok && !push_ok) begin
			level_o <= level_o - LW'(1);
		end
	end

	property p_level_bound;
		@(posedge clk_i) disable iff (!rstn_i)
		level_o <= LW'(DEPTH);
	endproperty
	a_level_bound: assert property (p_level_bound)
		else $error("fifo level beyond depth");
endmodule // irfs_level_track
`default_nettype wire

// File: logic/irfs_pkg.sv
// Purpose: shared constants and carriers for the infrared status bank
// Assumes: 16-bit register words on a plain strobe port
// Notes: offsets are byte addresses on the internal bus
`default_nettype none
package irfs_pkg;
	// register offsets
	localparam logic [31:0] TX_STATUS_ADDR = 32'h0C00_0066;
	localparam logic [31:0] RX_STATUS_ADDR = 32'h0C00_0068;
	localparam logic [31:0] IRQ_STATUS_ADDR = 32'h0C00_0070;
	localparam logic [31:0] IRQ_CLEAR_ADDR = 32'h0C00_0072;
	localparam logic [31:0] IRQ_ENABLE_ADDR = 32'h0C00_0074;
	// transmit status field positions
	localparam int TX_BUSY_BIT = 7;
	localparam int TX_SIZE_PEND_BIT = 5;
	localparam int TX_THRESH_BIT = 4;
	localparam int TX_UNDERRUN_BIT = 2;
	localparam int TX_NO_SPACE_BIT = 1;
	localparam int TX_PRESENT_BIT = 0;
	// receive status field positions
	localparam int RX_BUSY_BIT = 7;
	localparam int RX_END_DATA_BIT = 6;
	localparam int RX_SEVENTH_BIT = 5;
	localparam int RX_THRESH_BIT = 4;
	localparam int RX_NO_SPACE_BIT = 1;
	localparam int RX_PRESENT_BIT = 0;
	// interrupt status, clear and enable layout
	localparam int IRQ_W = 4;
	localparam int IRQ_TX_UNDERRUN = 0;
	localparam int IRQ_TX_DONE = 1;
	localparam int IRQ_RX_DONE = 2;
	localparam int IRQ_RX_SEVENTH = 3;
	// reset and initial values
	localparam logic [15:0] STATUS_RESET = 16'h0000;
	localparam logic [IRQ_W-1:0] IRQ_RESET = 4'h0;
	localparam logic SIZE_PEND_INIT = 1'b1;
	// receive result store depth in frames
	localparam int RESULT_SLOTS = 7;
	localparam int RESULT_LW = 3;

	// transmit side events from the framer, one-cycle pulses
	typedef struct packed {
		logic start_sent;  // preamble or start flag sent
		logic abort_sent;  // closing abort sent
		logic seq_done;    // start flag sequence finished
		logic push;        // word written to data fifo
		logic pop;         // word fetched by transmitter
		logic size_push;   // frame size entry written
		logic size_pop;    // frame size entry consumed
	} irfs_tx_evt_s;

	// receive side events from the deframer, one-cycle pulses
	typedef struct packed {
		logic start_det;    // preamble or start flag seen
		logic frame_end;    // reception finished
		logic push;         // word stored in data fifo
		logic push_last;    // stored word ends a frame
		logic pop;          // word read by software
		logic pop_last;     // read word ended a frame
		logic result_store; // size and status stored
		logic result_read;  // size and status read
		logic clear;        // receive fifo clear
	} irfs_rx_evt_s;
endpackage
`default_nettype wire

// File: logic/irfs_status_regs.sv
// Purpose: transmit and receive fifo status registers of the ir link
// Assumes: all event inputs come from logic on clk_i
// Notes: one reset input serves both the rtc and the other resets
`timescale 1ns/1ps
`default_nettype none
module irfs_status_regs #(
	parameter int TX_DEPTH = 16,
	parameter int RX_DEPTH = 16,
	parameter int SIZE_DEPTH = 8,
	parameter int TX_LW = $clog2(TX_DEPTH + 1),
	parameter int RX_LW = $clog2(RX_DEPTH + 1)
) (
	input wire logic clk_i,                     // core clock
	input wire logic rstn_i,                    // async reset, low
	input wire logic ir_enable_i,               // ir operation on
	input wire irfs_pkg::irfs_tx_evt_s tx_evt_i, // transmit events
	input wire irfs_pkg::irfs_rx_evt_s rx_evt_i, // receive events
	input wire logic [TX_LW-1:0] tx_thresh_i,   // tx threshold
	input wire logic [RX_LW-1:0] rx_thresh_i,   // rx threshold
	input wire logic [31:0] addr_i,             // register address
	input wire logic [15:0] wr_data_i,          // write data
	input wire logic wr_i,                      // write strobe
	input wire logic rd_i,                      // read strobe
	output logic [15:0] rd_data_o,              // read data, next cycle
	output logic irq_o                          // level interrupt
);
	logic ir_en_q;
	logic en_rise;
	logic tx_clr;
	logic rx_clr;
	logic tx_busy;
	logic tx_size_pend;
	logic tx_underrun;
	logic tx_full;
	logic tx_empty;
	logic tx_above;
	logic size_empty;
	logic rx_busy;
	logic [RX_LW-1:0] rx_last_cnt;
	logic rx_full;
	logic rx_empty;
	logic rx_above;
	logic [irfs_pkg::RESULT_LW-1:0] res_level;
	logic rx_seventh;
	logic rx_seventh_q;
	logic underrun_evt;
	logic [15:0] tx_word;
	logic [15:0] rx_word;
	logic [irfs_pkg::IRQ_W-1:0] irq_status;
	logic [irfs_pkg::IRQ_W-1:0] irq_enable;
	logic [irfs_pkg::IRQ_W-1:0] irq_evt;
	logic [irfs_pkg::IRQ_W-1:0] irq_clr;
	logic [15:0] next_rd_data;

	// stopping ir flushes every tracker, so enabling starts clean
	assign en_rise = ir_enable_i && !ir_en_q;
	assign tx_clr = !ir_enable_i;
	assign rx_clr = !ir_enable_i || rx_evt_i.clear;

	// enable edge detect
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ir_en_q <= 1'b0;
		end else begin
			ir_en_q <= ir_enable_i;
		end
	end

	// transmit data fifo occupancy
	irfs_level_track #(.DEPTH(TX_DEPTH), .LW(TX_LW)) u_tx_level (
		.clk_i(clk_i), .rstn_i(rstn_i), .clr_i(tx_clr),
		.push_i(tx_evt_i.push), .pop_i(tx_evt_i.pop),
		.thresh_i(tx_thresh_i), .level_o(), .full_o(tx_full),
		.empty_o(tx_empty), .above_o(tx_above)
	);
	// transmit frame size fifo, threshold unused
	irfs_level_track #(.DEPTH(SIZE_DEPTH)) u_size_level (
		.clk_i(clk_i), .rstn_i(rstn_i), .clr_i(tx_clr),
		.push_i(tx_evt_i.size_push), .pop_i(tx_evt_i.size_pop),
		.thresh_i('0), .level_o(), .full_o(),
		.empty_o(size_empty), .above_o()
	);
	// receive data fifo occupancy
	irfs_level_track #(.DEPTH(RX_DEPTH), .LW(RX_LW)) u_rx_level (
		.clk_i(clk_i), .rstn_i(rstn_i), .clr_i(rx_clr),
		.push_i(rx_evt_i.push), .pop_i(rx_evt_i.pop),
		.thresh_i(rx_thresh_i), .level_o(), .full_o(rx_full),
		.empty_o(rx_empty), .above_o(rx_above)
	);
	// result store: a store beyond seven frames is dropped
	irfs_level_track #(.DEPTH(irfs_pkg::RESULT_SLOTS),
		.LW(irfs_pkg::RESULT_LW)) u_res_level (
		.clk_i(clk_i), .rstn_i(rstn_i), .clr_i(rx_clr),
		.push_i(rx_evt_i.result_store), .pop_i(rx_evt_i.result_read),
		.thresh_i('0), .level_o(res_level), .full_o(),
		.empty_o(), .above_o()
	);

	assign rx_seventh = (res_level ==
		irfs_pkg::RESULT_LW'(irfs_pkg::RESULT_SLOTS));

	// tx busy: a new start in the abort cycle keeps it set
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			tx_busy <= 1'b0;
		end else if (!ir_enable_i) begin
			tx_busy <= 1'b0;
		end else if (tx_evt_i.start_sent) begin
			tx_busy <= 1'b1;
		end else if (tx_evt_i.abort_sent) begin
			tx_busy <= 1'b0;
		end
	end

	// size pending only samples the size fifo at sequence end
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			tx_size_pend <= 1'b0;
		end else if (en_rise) begin
			tx_size_pend <= irfs_pkg::SIZE_PEND_INIT;
		end else if (tx_evt_i.seq_done) begin
			tx_size_pend <= !size_empty;
		end
	end

	// underrun stands until fresh data arrives or ir stops; set beats clear
	assign underrun_evt = tx_evt_i.pop && tx_empty && ir_enable_i;
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			tx_underrun <= 1'b0;
		end else if (underrun_evt) begin
			tx_underrun <= 1'b1;
		end else if (tx_evt_i.push || tx_clr) begin
			tx_underrun <= 1'b0;
		end
	end

	// rx busy follows the frame on the wire
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rx_busy <= 1'b0;
		end else if (rx_clr) begin
			rx_busy <= 1'b0;
		end else if (rx_evt_i.start_det) begin
			rx_busy <= 1'b1;
		end else if (rx_evt_i.frame_end) begin
			rx_busy <= 1'b0;
		end
	end

	// count of frame-final words held; one-word frames can fill the fifo
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rx_last_cnt <= '0;
		end else if (rx_clr) begin
			rx_last_cnt <= '0;
		end else begin
			case ({rx_evt_i.push && rx_evt_i.push_last && !rx_full,
				rx_evt_i.pop && rx_evt_i.pop_last &&
				rx_last_cnt != '0})
				2'b10: rx_last_cnt <= rx_last_cnt + RX_LW'(1);
				2'b01: rx_last_cnt <= rx_last_cnt - RX_LW'(1);
				default: rx_last_cnt <= rx_last_cnt;
			endcase
		end
	end

	// live status words; reserved lanes tied low
	always_comb begin
		tx_word = irfs_pkg::STATUS_RESET;
		rx_word = irfs_pkg::STATUS_RESET;
		if (ir_enable_i) begin
			tx_word[irfs_pkg::TX_BUSY_BIT] = tx_busy;
			tx_word[irfs_pkg::TX_SIZE_PEND_BIT] = tx_size_pend;
			tx_word[irfs_pkg::TX_THRESH_BIT] = tx_above;
			tx_word[irfs_pkg::TX_UNDERRUN_BIT] = tx_underrun;
			tx_word[irfs_pkg::TX_NO_SPACE_BIT] = tx_full;
			tx_word[irfs_pkg::TX_PRESENT_BIT] = !tx_empty;
			rx_word[irfs_pkg::RX_BUSY_BIT] = rx_busy;
			rx_word[irfs_pkg::RX_END_DATA_BIT] = rx_last_cnt != '0;
			rx_word[irfs_pkg::RX_SEVENTH_BIT] = rx_seventh;
			rx_word[irfs_pkg::RX_THRESH_BIT] = rx_above;
			rx_word[irfs_pkg::RX_NO_SPACE_BIT] = rx_full;
			rx_word[irfs_pkg::RX_PRESENT_BIT] = !rx_empty;
		end
	end

	// seventh-result edge for the interrupt
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rx_seventh_q <= 1'b0;
		end else begin
			rx_seventh_q <= rx_seventh;
		end
	end

	// interrupt events and software clear mask
	always_comb begin
		irq_evt = '0;
		irq_evt[irfs_pkg::IRQ_TX_UNDERRUN] = underrun_evt;
		irq_evt[irfs_pkg::IRQ_TX_DONE] = tx_evt_i.abort_sent && ir_enable_i;
		irq_evt[irfs_pkg::IRQ_RX_DONE] = rx_evt_i.frame_end && ir_enable_i;
		irq_evt[irfs_pkg::IRQ_RX_SEVENTH] = rx_seventh && !rx_seventh_q;
		irq_clr = '0;
		if (wr_i && addr_i == irfs_pkg::IRQ_CLEAR_ADDR) begin
			irq_clr = wr_data_i[irfs_pkg::IRQ_W-1:0];
		end
	end

	// sticky flags, an event in the clear cycle survives
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			irq_status <= irfs_pkg::IRQ_RESET;
		end else begin
			irq_status <= (irq_status & ~irq_clr) | irq_evt;
		end
	end

	// interrupt enable register
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			irq_enable <= irfs_pkg::IRQ_RESET;
		end else if (wr_i && addr_i == irfs_pkg::IRQ_ENABLE_ADDR) begin
			irq_enable <= wr_data_i[irfs_pkg::IRQ_W-1:0];
		end
	end

	assign irq_o = |(irq_status & irq_enable);

	// read mux; status words ignore writes, unmapped reads give zero
	always_comb begin
		next_rd_data = 16'h0000;
		if (rd_i) begin
			case (addr_i)
				irfs_pkg::TX_STATUS_ADDR: next_rd_data = tx_word;
				irfs_pkg::RX_STATUS_ADDR: next_rd_data = rx_word;
				irfs_pkg::IRQ_STATUS_ADDR:
					next_rd_data = {12'h000, irq_status};
				irfs_pkg::IRQ_ENABLE_ADDR:
					next_rd_data = {12'h000, irq_enable};
				default: next_rd_data = 16'h0000;
			endcase
		end
	end

	// read data stand for one cycle only
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rd_data_o <= irfs_pkg::STATUS_RESET;
		end else begin
			rd_data_o <= next_rd_data;
		end
	end

	sequence s_tx_read;
		rd_i && addr_i == irfs_pkg::TX_STATUS_ADDR;
	endsequence

	sequence s_rx_read;
		rd_i && addr_i == irfs_pkg::RX_STATUS_ADDR;
	endsequence

	sequence s_rx_frame_open;
		rx_evt_i.start_det && ir_enable_i && !rx_evt_i.clear
		##1 (!rx_evt_i.frame_end && !rx_clr)[*2];
	endsequence

	property p_tx_busy_read;
		@(posedge clk_i) disable iff (!rstn_i)
		tx_evt_i.start_sent && ir_enable_i ##1 ir_enable_i &&
		!tx_evt_i.abort_sent ##0 s_tx_read |=> rd_data_o[7];
	endproperty
	a_tx_busy_read: assert property (p_tx_busy_read)
		else $error("tx busy not shown after start");

	property p_size_pend_init;
		@(posedge clk_i) disable iff (!rstn_i)
		en_rise |=> tx_size_pend;
	endproperty
	a_size_pend_init: assert property (p_size_pend_init)
		else $error("size pending not one after enable");

	property p_size_pend_hold;
		@(posedge clk_i) disable iff (!rstn_i)
		!en_rise && !tx_evt_i.seq_done |=> $stable(tx_size_pend);
	endproperty
	a_size_pend_hold: assert property (p_size_pend_hold)
		else $error("size pending moved outside sequence end");

	property p_underrun_read;
		@(posedge clk_i) disable iff (!rstn_i)
		underrun_evt ##1 (ir_enable_i && !tx_evt_i.push) ##0 s_tx_read
		|=> rd_data_o[2];
	endproperty
	a_underrun_read: assert property (p_underrun_read)
		else $error("underrun not reported");

	property p_stopped_zero;
		@(posedge clk_i) disable iff (!rstn_i)
		!ir_enable_i && (rd_i && (addr_i == irfs_pkg::TX_STATUS_ADDR ||
		addr_i == irfs_pkg::RX_STATUS_ADDR)) |=> rd_data_o == 16'h0000;
	endproperty
	a_stopped_zero: assert property (p_stopped_zero)
		else $error("status nonzero while ir stopped");

	property p_reserved_zero;
		@(posedge clk_i) disable iff (!rstn_i)
		s_tx_read or s_rx_read |=>
		rd_data_o[15:8] == 8'h00 && rd_data_o[3] == 1'b0;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero)
		else $error("reserved status bit set");

	property p_rx_busy_hold;
		@(posedge clk_i) disable iff (!rstn_i)
		s_rx_frame_open |-> rx_busy;
	endproperty
	a_rx_busy_hold: assert property (p_rx_busy_hold)
		else $error("rx busy dropped inside frame");

	property p_seventh_read;
		@(posedge clk_i) disable iff (!rstn_i)
		s_rx_read ##0 (ir_enable_i && rx_seventh) |=> rd_data_o[5];
	endproperty
	a_seventh_read: assert property (p_seventh_read)
		else $error("seventh result flag not read back");

	property p_rx_clear_init;
		@(posedge clk_i) disable iff (!rstn_i)
		rx_evt_i.clear |=> !rx_busy && rx_last_cnt == '0 &&
		res_level == '0;
	endproperty
	a_rx_clear_init: assert property (p_rx_clear_init)
		else $error("rx state not initial after clear");

	property p_irq_done;
		@(posedge clk_i) disable iff (!rstn_i)
		tx_evt_i.abort_sent && ir_enable_i &&
		irq_enable[irfs_pkg::IRQ_TX_DONE] &&
		!(wr_i && addr_i == irfs_pkg::IRQ_ENABLE_ADDR) |=> irq_o;
	endproperty
	a_irq_done: assert property (p_irq_done)
		else $error("enabled event raised no interrupt");
endmodule // irfs_status_regs
`default_nettype wire

// File: test/irfs_link_model.sv
// Purpose: far-side link model that pulses framer and deframer events
// Assumes: events change just after a rising clock edge
// Notes: waits 1 to 3 clock edges before each command, prompt or slow
`timescale 1ns/1ps
`default_nettype none
module irfs_link_model (
	input wire logic clk_i,                       // core clock
	output var irfs_pkg::irfs_tx_evt_s tx_evt_o,  // transmit events
	output var irfs_pkg::irfs_rx_evt_s rx_evt_o   // receive events
);
	// idle, nothing pending
	initial begin
		tx_evt_o = '0;
		rx_evt_o = '0;
	end
	// hold a transmit event for n edges, then drop to idle
	task automatic tx_pulse(input irfs_pkg::irfs_tx_evt_s e, input int n);
		repeat ($urandom_range(2)) @(posedge clk_i);
		@(posedge clk_i);
		tx_evt_o <= e;
		repeat (n) @(posedge clk_i);
		tx_evt_o <= '0;
	endtask
	// same for the receive side
	task automatic rx_pulse(input irfs_pkg::irfs_rx_evt_s e, input int n);
		repeat ($urandom_range(2)) @(posedge clk_i);
		@(posedge clk_i);
		rx_evt_o <= e;
		repeat (n) @(posedge clk_i);
		rx_evt_o <= '0;
	endtask
endmodule // irfs_link_model
`default_nettype wire

// File: test/tb_irfs_status_regs.sv
// Purpose: self-checking bench for the infrared status bank
// Assumes: data fifo depths of 16, link model drives all events
// Notes: ir is toggled off and on to flush between trials
`timescale 1ns/1ps
`default_nettype none
module tb_irfs_status_regs;
	localparam logic [31:0] TXA = irfs_pkg::TX_STATUS_ADDR;
	localparam logic [31:0] RXA = irfs_pkg::RX_STATUS_ADDR;
	localparam logic [31:0] ISA = irfs_pkg::IRQ_STATUS_ADDR;
	localparam logic [31:0] ICA = irfs_pkg::IRQ_CLEAR_ADDR;
	localparam logic [31:0] IEA = irfs_pkg::IRQ_ENABLE_ADDR;
	logic clk_i = 1'b0;
	logic rstn_i = 1'b0;
	logic ir_enable_i = 1'b0;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic [31:0] addr_i = '0;
	logic [15:0] wr_data_i = '0;
	logic [4:0] tx_thresh_i = '0;
	logic [4:0] rx_thresh_i = '0;
	logic [15:0] rd_data_o;
	logic irq_o;
	irfs_pkg::irfs_tx_evt_s tx_evt;
	irfs_pkg::irfs_rx_evt_s rx_evt;
	int fail_count = 0;
	int check_count = 0;
	int n;
	int thr;
	// 125 MHz core clock
	always #4 clk_i = ~clk_i;
	irfs_status_regs #(.TX_DEPTH(16), .RX_DEPTH(16)) dut_u (
		.clk_i(clk_i), .rstn_i(rstn_i), .ir_enable_i(ir_enable_i),
		.tx_evt_i(tx_evt), .rx_evt_i(rx_evt), .tx_thresh_i(tx_thresh_i),
		.rx_thresh_i(rx_thresh_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
		.wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o), .irq_o(irq_o)
	);
	irfs_link_model link_u (
		.clk_i(clk_i), .tx_evt_o(tx_evt), .rx_evt_o(rx_evt)
	);
	// occupancy bits shared by both status words
	function automatic logic [15:0] fifo_bits(input int cnt, input int th);
		fifo_bits = '0;
		fifo_bits[irfs_pkg::TX_PRESENT_BIT] = (cnt > 0);
		fifo_bits[irfs_pkg::TX_NO_SPACE_BIT] = (cnt == 16);
		fifo_bits[irfs_pkg::TX_THRESH_BIT] = (cnt > th);
	endfunction
	// word compare, case equality so unknowns never match
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// interrupt line compare
	task automatic check_irq(input logic exp);
		check_count++;
		if (irq_o !== exp) begin
			fail_count++;
			$display("mismatch at %0t: irq line not %b", $time, exp);
		end
	endtask
	// one-cycle write strobe
	task automatic wr(input logic [31:0] a, input logic [15:0] d);
		@(posedge clk_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wr_data_i <= d;
		@(posedge clk_i);
		wr_i <= 1'b0;
		#1;
	endtask
	// one-cycle read strobe, data checked in the cycle after
	task automatic rd(input logic [31:0] a, input logic [15:0] exp);
		@(posedge clk_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1;
		check(rd_data_o, exp);
	endtask
	// drop then raise ir enable, flushing every counter
	task automatic restart();
		@(posedge clk_i);
		ir_enable_i <= 1'b0;
		@(posedge clk_i);
		ir_enable_i <= 1'b1;
	endtask
	task automatic end_test(input string s);
		$display("test %s done at %0t", s, $time);
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// watchdog, far beyond the several hundred cycles the tests need
	initial begin
		#200000;
		fail_count++;
		$display("mismatch at %0t: watchdog expired", $time);
		conclude();
	end
	// main sequence
	initial begin
		void'($urandom(32'hF6CC852A));
		repeat (4) @(posedge clk_i);
		rstn_i <= 1'b1;
		rd(TXA, 16'h0000);
		rd(RXA, 16'h0000);
		end_test("reset");
		restart();
		rd(TXA, 16'h0020);
		rd(RXA, 16'h0000);
		wr(TXA, 16'hFFFF);
		wr(RXA, 16'hFFFF);
		rd(TXA, 16'h0020);
		rd(RXA, 16'h0000);
		rd(32'h0C00_0060, 16'h0000);
		end_test("access");
		// random fill levels against random thresholds, ends forced
		for (int i = 0; i < 12; i++) begin
			n = (i == 0) ? 16 : (i == 1) ? 0 : $urandom_range(16);
			thr = (i == 0) ? 15 : $urandom_range(15);
			tx_thresh_i <= 5'(thr);
			rx_thresh_i <= 5'(thr);
			restart();
			if (n > 0) begin
				link_u.tx_pulse('{push:1'b1, default:1'b0}, n);
				link_u.rx_pulse('{push:1'b1, default:1'b0}, n);
			end
			rd(TXA, 16'h0020 | fifo_bits(n, thr));
			rd(RXA, fifo_bits(n, thr));
		end
		end_test("levels");
		tx_thresh_i <= 5'h0F;
		restart();
		link_u.tx_pulse('{start_sent:1'b1, default:1'b0}, 1);
		rd(TXA, 16'h00A0);
		wr(IEA, 16'h0002);
		link_u.tx_pulse('{abort_sent:1'b1, default:1'b0}, 1);
		rd(TXA, 16'h0020);
		check_irq(1'b1);
		// underrun, first masked then enabled
		wr(IEA, 16'h0000);
		link_u.tx_pulse('{pop:1'b1, default:1'b0}, 1);
		rd(TXA, 16'h0024);
		check_irq(1'b0);
		rd(ISA, 16'h0003);
		wr(IEA, 16'h0001);
		check_irq(1'b1);
		wr(ICA, 16'h0001);
		check_irq(1'b0);
		rd(ISA, 16'h0002);
		link_u.tx_pulse('{push:1'b1, default:1'b0}, 1);
		rd(TXA, 16'h0021);
		end_test("busy and underrun");
		restart();
		link_u.tx_pulse('{seq_done:1'b1, default:1'b0}, 1);
		rd(TXA, 16'h0000);
		link_u.tx_pulse('{size_push:1'b1, default:1'b0}, 1);
		rd(TXA, 16'h0000);
		link_u.tx_pulse('{seq_done:1'b1, default:1'b0}, 1);
		rd(TXA, 16'h0020);
		link_u.tx_pulse('{size_pop:1'b1, default:1'b0}, 1);
		rd(TXA, 16'h0020);
		link_u.tx_pulse('{seq_done:1'b1, default:1'b0}, 1);
		rd(TXA, 16'h0000);
		end_test("size pending");
		// one whole received frame, then the result store
		n = $urandom_range(16, 2);
		thr = $urandom_range(15);
		rx_thresh_i <= 5'(thr);
		restart();
		link_u.rx_pulse('{start_det:1'b1, default:1'b0}, 1);
		rd(RXA, 16'h0080);
		link_u.rx_pulse('{push:1'b1, default:1'b0}, n - 1);
		link_u.rx_pulse('{push:1'b1, push_last:1'b1, default:1'b0}, 1);
		link_u.rx_pulse('{frame_end:1'b1, default:1'b0}, 1);
		rd(RXA, 16'h0040 | fifo_bits(n, thr));
		link_u.rx_pulse('{result_store:1'b1, default:1'b0}, 6);
		rd(RXA, 16'h0040 | fifo_bits(n, thr));
		link_u.rx_pulse('{result_store:1'b1, default:1'b0}, 2);
		rd(RXA, 16'h0060 | fifo_bits(n, thr));
		link_u.rx_pulse('{result_read:1'b1, default:1'b0}, 1);
		rd(RXA, 16'h0040 | fifo_bits(n, thr));
		link_u.rx_pulse('{pop:1'b1, default:1'b0}, n - 1);
		link_u.rx_pulse('{pop:1'b1, pop_last:1'b1, default:1'b0}, 1);
		rd(RXA, 16'h0000);
		link_u.rx_pulse('{push:1'b1, default:1'b0}, 3);
		link_u.rx_pulse('{clear:1'b1, default:1'b0}, 1);
		rd(RXA, 16'h0000);
		// frame end and seventh result both latched, then cleared
		rd(ISA, 16'h000E);
		wr(ICA, 16'h000F);
		rd(ISA, 16'h0000);
		end_test("receive frame");
		// reset in mid-run with ir left on: state back to initial
		restart();
		link_u.tx_pulse('{push:1'b1, default:1'b0}, 2);
		wr(IEA, 16'h0002);
		@(posedge clk_i);
		rstn_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		rstn_i <= 1'b1;
		rd(TXA, 16'h0020);
		rd(IEA, 16'h0000);
		end_test("mid reset");
		link_u.tx_pulse('{push:1'b1, default:1'b0}, 2);
		@(posedge clk_i);
		ir_enable_i <= 1'b0;
		rd(TXA, 16'h0000);
		rd(RXA, 16'h0000);
		end_test("stopped");
		conclude();
	end
endmodule // tb_irfs_status_regs
`default_nettype wire
